//--- hdl/undervoltage_pickup_block.sv
// Behaviour
// [RULE_01] two-bit code selects P-P, P-E, third or fourth channel; P-P default
// [RULE_02] pre-fault value is 20 ms average ending at START or TRIP
// [RULE_03] P-P and P-E use three channels, two in the aux arrangement
// [RULE_04] fourth always channel four; third only in the aux arrangement
// [RULE_05] five operating modes, effective only when individual mode allowed
// [RULE_06] forced state Normal/Start/Trip/Blocked overrides outputs when forcing enabled
// [RULE_07] mode and forcing settings are static, untouched by setting groups
// [RULE_08] pick-up when any supervised voltage is under the common level
// [RULE_09] pick-up releases only above a fixed 103 percent of level
// [RULE_10] block level in 0.01 percent, default ten; zero disables it
// [RULE_11] START needs pick-up and no blocking condition
// [RULE_12] under block level inhibits trip until all voltages exceed pick-up
// [RULE_13] pick-up and block levels shown in primary volts, 0.1 V steps
// [RULE_14] expected operating time shown in 5 ms steps
// [RULE_15] remaining time to trip counts down in 5 ms steps
// [RULE_16] ratio measured to pick-up in hundredths per voltage and lowest
// [RULE_17] effective operating mode readable with the same five codes
// [RULE_18] external block at pick-up gives BLOCKED instead of START
// [RULE_19] definite time trips after delay of continuous pick-up
// [RULE_20] everything evaluated once per cycle, outputs updated together; the primary level displays are recomputed every clock instead
`timescale 1ns/1ps
`default_nettype none

module undervoltage_pickup_block #(
    parameter int P_TICK_CYCLES = uvp_pkg::TICK_CYCLES_DFLT
) (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    // measurements and external block pin
    input  wire uvp_pkg::meas_s      i_meas,
    input  wire logic                i_ext_block,
    // register port
    input  wire uvp_pkg::regbus_s    i_bus,
    output logic [31:0]              o_rdata,
    // stage outputs
    output uvp_pkg::stage_out_s      o_stage
);
    import uvp_pkg::*;

    typedef struct packed {
        logic [17:0]                div;
        logic                       sync1;
        logic                       sync2;
        logic [1:0]                 sel;
        logic                       arr;
        logic [2:0]                 mode;
        logic [1:0]                 frc;
        logic                       allow;
        logic                       fen;
        logic [15:0]                pickup;
        logic [15:0]                blk_lvl;
        logic [15:0]                delay;
        logic [15:0]                scale;
        stage_e                     state;
        logic                       picked;
        logic                       inhibit;
        logic                       force_act;
        logic [2:0]                 eff_mode;
        logic [15:0]                elapsed;
        logic [AVG_TAPS-1:0][15:0]  hist;
        logic [15:0]                prefault;
        logic [3:0][19:0]           ratio;
        logic [31:0]                pri_pu;
        logic [31:0]                pri_bl;
        logic [15:0]                remain;
        stage_out_s                 out;
        logic [31:0]                rdata;
    } state_s;

    state_s r;
    state_s next_r;

    logic              tick;
    logic [2:0][15:0]  volt;
    logic [2:0]        ena;
    logic              under_any;
    logic              rec_all;
    logic              above_all;
    logic [15:0]       min_v;
    logic [17:0]       avg_sum;
    logic [15:0]       avg;
    logic [2:0]        eff_mode;
    logic              block_any;

    assign tick = (r.div == 18'(P_TICK_CYCLES - 1));
    // selection code and arrangement bit alone steer the channel map, never the setting group
    assign eff_mode = r.allow ? r.mode : MODE_ON; // see [RULE_05]

    // supervised magnitude selection
    always_comb begin
        volt = {3{16'hffff}};
        ena  = 3'h0;
        case (r.sel)
            SEL_PP: begin
                volt = i_meas.line; // see [RULE_01]
                ena  = r.arr ? 3'h3 : 3'h7; // see [RULE_03]
            end
            SEL_PE: begin
                volt = i_meas.phase;
                ena  = r.arr ? 3'h3 : 3'h7; // see [RULE_03]
            end
            SEL_CH3: begin
                volt[0] = i_meas.ch3;
                ena     = r.arr ? 3'h1 : 3'h0; // see [RULE_04]
            end
            default: begin
                volt[0] = i_meas.ch4; // see [RULE_04]
                ena     = 3'h1;
            end
        endcase
    end

    // comparisons against the common level
    always_comb begin
        under_any = 1'b0;
        rec_all   = 1'b1;
        above_all = 1'b1;
        min_v     = 16'hffff;
        for (int i = 0; i < 3; i++) begin
            if (ena[i]) begin
                if (volt[i] < r.pickup) begin
                    under_any = 1'b1; // see [RULE_08]
                end
                // 103 percent hysteresis, kept in products to avoid a divider
                if (32'(volt[i]) * HUNDRED < 32'(r.pickup) * RESET_PCT) begin
                    rec_all = 1'b0; // see [RULE_09]
                end
                if (volt[i] <= r.pickup) begin
                    above_all = 1'b0;
                end
                if (volt[i] < min_v) begin
                    min_v = volt[i];
                end
            end
        end
    end

    // sliding 20 ms history of the lowest magnitude
    always_comb begin
        avg_sum = 18'h0;
        for (int i = 0; i < AVG_TAPS; i++) begin
            avg_sum = avg_sum + 18'(r.hist[i]);
        end
        avg = 16'(avg_sum / 18'(AVG_TAPS));
    end

    // next state: register port, evaluation, outputs
    always_comb begin
        next_r       = r;
        block_any    = 1'b0;
        next_r.sync1 = i_ext_block;
        next_r.sync2 = r.sync1;
        next_r.div   = tick ? 18'h0 : r.div + 18'h1;
        next_r.rdata = 32'h0;

        // writes; no setting-group input reaches these fields
        if (i_bus.wr) begin
            case (i_bus.addr)
                A_CTRL: begin
                    next_r.sel   = i_bus.wdata[CTRL_SEL+:2];
                    next_r.arr   = i_bus.wdata[CTRL_ARR];
                    next_r.mode  = i_bus.wdata[CTRL_MODE+:3]; // see [RULE_07]
                    next_r.frc   = i_bus.wdata[CTRL_FRC+:2]; // see [RULE_07]
                    next_r.allow = i_bus.wdata[CTRL_ALLOW];
                    next_r.fen   = i_bus.wdata[CTRL_FEN];
                end
                A_PICKUP: next_r.pickup = i_bus.wdata[15:0];
                A_BLOCK:  next_r.blk_lvl = i_bus.wdata[15:0]; // see [RULE_10]
                A_DELAY:  next_r.delay = i_bus.wdata[15:0];
                A_SCALE:  next_r.scale = i_bus.wdata[15:0];
                default: begin
                end
            endcase
        end

        // reads, answered in the following cycle; unmapped reads as zero
        if (i_bus.rd) begin
            case (i_bus.addr)
                A_CTRL: next_r.rdata = 32'({r.fen, r.allow, r.frc, r.mode, r.arr, r.sel});
                A_PICKUP: next_r.rdata = 32'(r.pickup);
                A_BLOCK:  next_r.rdata = 32'(r.blk_lvl);
                A_DELAY:  next_r.rdata = 32'(r.delay);
                A_SCALE:  next_r.rdata = 32'(r.scale);
                A_STATUS: next_r.rdata = 32'({r.eff_mode, r.state, r.inhibit,
                                              r.picked, r.out}); // see [RULE_17]
                A_PRI_PU: next_r.rdata = r.pri_pu;
                A_PRI_BL: next_r.rdata = r.pri_bl;
                A_EXPECT: next_r.rdata = 32'(r.delay); // see [RULE_14]
                A_REMAIN: next_r.rdata = 32'(r.remain);
                A_PREF:   next_r.rdata = 32'(r.prefault);
                default: begin
                    if (i_bus.addr >= A_RATIO0 && i_bus.addr <= A_RATIOM) begin
                        next_r.rdata = 32'(r.ratio[2'(i_bus.addr - A_RATIO0)]);
                    end
                end
            endcase
        end

        // one evaluation per cycle; all outputs move on the same edge
        if (tick) begin // see [RULE_20]
            next_r.eff_mode = eff_mode;
            next_r.picked   = r.picked ? !rec_all : under_any; // see [RULE_09]

            // de-energised inhibit: setting wins over clearing
            if (r.blk_lvl == 16'h0) begin
                next_r.inhibit = 1'b0; // see [RULE_10]
            end else if (ena != 3'h0 && min_v < r.blk_lvl) begin
                next_r.inhibit = 1'b1; // see [RULE_12]
            end else if (above_all) begin
                next_r.inhibit = 1'b0; // see [RULE_12]
            end

            block_any = r.sync2 || eff_mode == MODE_BLK || eff_mode == MODE_TBLK
                        || next_r.inhibit;

            case (r.state)
                ST_IDLE: begin
                    next_r.elapsed = 16'h0;
                    if (next_r.picked) begin
                        if (block_any) begin
                            next_r.state = ST_BLOCKED; // see [RULE_18]
                        end else if (r.delay == 16'h0) begin
                            next_r.state = ST_TRIP;
                        end else begin
                            next_r.state = ST_START; // see [RULE_11]
                        end
                    end
                end
                ST_START: begin
                    next_r.elapsed = r.elapsed + 16'h1;
                    if (!next_r.picked) begin
                        next_r.state = ST_IDLE;
                    end else if (block_any) begin
                        next_r.state = ST_BLOCKED; // see [RULE_11]
                    end else if (r.elapsed + 16'h1 >= r.delay) begin
                        next_r.state = ST_TRIP; // see [RULE_19]
                    end
                end
                ST_TRIP: begin
                    if (!next_r.picked) begin
                        next_r.state = ST_IDLE;
                    end
                end
                default: begin
                    // a blocked pick-up is not processed further
                    if (!next_r.picked) begin
                        next_r.state = ST_IDLE; // see [RULE_18]
                    end
                end
            endcase
            if (eff_mode == MODE_OFF) begin
                next_r.state = ST_IDLE;
            end

            next_r.out.start   = next_r.state == ST_START || next_r.state == ST_TRIP;
            next_r.out.trip    = next_r.state == ST_TRIP;
            next_r.out.blocked = next_r.state == ST_BLOCKED;

            // forcing overrides the computed outputs while enabled
            next_r.force_act = r.fen && r.frc != FRC_NORMAL; // see [RULE_06]
            if (next_r.force_act) begin
                next_r.out.start   = r.frc == FRC_START || r.frc == FRC_TRIP;
                next_r.out.trip    = r.frc == FRC_TRIP;
                next_r.out.blocked = r.frc == FRC_BLOCK;
            end

            // pre-fault capture uses the window before the new sample
            if ((next_r.out.start && !r.out.start) || (next_r.out.trip && !r.out.trip)) begin
                next_r.prefault = avg; // see [RULE_02]
            end
            next_r.hist = {r.hist[AVG_TAPS-2:0], min_v};

            // ratios in hundredths; a zero level reads as full scale
            for (int i = 0; i < 4; i++) begin
                if (r.pickup == 16'h0) begin
                    next_r.ratio[i] = 20'hfffff;
                end else begin
                    next_r.ratio[i] = 20'(32'(i < 3 ? volt[i < 3 ? i : 0] : min_v) * HUNDRED
                                          / 32'(r.pickup)); // see [RULE_16]
                end
                if (i < 3 && !ena[i < 3 ? i : 0]) begin
                    next_r.ratio[i] = 20'h0;
                end
            end

            next_r.remain = next_r.state == ST_START
                            ? r.delay - next_r.elapsed : 16'h0; // see [RULE_15]
        end

        // primary volts in 0.1 V, every cycle so the display is valid right after reset
        next_r.pri_pu = 32'(r.pickup) * 32'(r.scale) / PRIM_DIV; // see [RULE_13]
        next_r.pri_bl = 32'(r.blk_lvl) * 32'(r.scale) / PRIM_DIV; // see [RULE_13]
    end

    // one register for all state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r          <= '0;
            r.mode     <= MODE_ON;
            r.eff_mode <= MODE_ON;
            r.sel      <= SEL_PP; // see [RULE_01]
            r.pickup   <= RST_PICKUP;
            r.blk_lvl  <= RST_BLOCK; // see [RULE_10]
            r.delay    <= RST_DELAY;
            r.scale    <= RST_SCALE;
            r.state    <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign o_rdata = r.rdata;
    assign o_stage = r.out;

    // checks on the stage behaviour
    property p_tick_only;
        @(posedge i_clk) disable iff (i_rst)
        $changed(r.out) |-> $past(tick);
    endproperty
    a_tick_only: assert property (p_tick_only) // see [RULE_20]
        else $error("outputs changed outside an evaluation cycle");

    property p_start_clean;
        @(posedge i_clk) disable iff (i_rst)
        (r.out.start && !r.force_act) |-> r.picked && (r.state inside {ST_START, ST_TRIP});
    endproperty
    a_start_clean: assert property (p_start_clean) // see [RULE_11]
        else $error("start without a clean pick-up");

    property p_blocked_out;
        @(posedge i_clk) disable iff (i_rst)
        (r.state == ST_BLOCKED && !r.force_act) |-> r.out.blocked && !r.out.start;
    endproperty
    a_blocked_out: assert property (p_blocked_out) // see [RULE_18]
        else $error("blocked pick-up still shows start");

    property p_dt_trip;
        @(posedge i_clk) disable iff (i_rst)
        ($past(r.state) == ST_START && r.state == ST_TRIP) |-> r.elapsed == $past(r.delay);
    endproperty
    a_dt_trip: assert property (p_dt_trip) // see [RULE_19]
        else $error("definite time trip at wrong count");

    property p_trip_not_inhibited;
        @(posedge i_clk) disable iff (i_rst)
        $rose(r.state == ST_TRIP) |-> !r.inhibit;
    endproperty
    a_trip_not_inhibited: assert property (p_trip_not_inhibited) // see [RULE_12]
        else $error("trip entered while de-energised");

    property p_zero_block;
        @(posedge i_clk) disable iff (i_rst)
        (tick && r.blk_lvl == 16'h0) |=> !r.inhibit;
    endproperty
    a_zero_block: assert property (p_zero_block) // see [RULE_10]
        else $error("zero block level still inhibits");

    property p_mode_off;
        @(posedge i_clk) disable iff (i_rst)
        ($past(tick) && $past(eff_mode) == MODE_OFF && !r.force_act)
            |-> r.out == 3'h0;
    endproperty
    a_mode_off: assert property (p_mode_off) // see [RULE_05]
        else $error("off mode drives outputs");

    property p_force_trip;
        @(posedge i_clk) disable iff (i_rst)
        ($past(tick) && $past(r.fen) && $past(r.frc) == FRC_TRIP)
            |-> r.out.trip && !r.out.blocked;
    endproperty
    a_force_trip: assert property (p_force_trip) // see [RULE_06]
        else $error("forced trip not shown");

    property p_release;
        @(posedge i_clk) disable iff (i_rst)
        $fell(r.picked) |-> $past(rec_all);
    endproperty
    a_release: assert property (p_release) // see [RULE_09]
        else $error("pick-up released below 103 percent");

    property p_pickup;
        @(posedge i_clk) disable iff (i_rst)
        (tick && under_any) |=> r.picked;
    endproperty
    a_pickup: assert property (p_pickup) // see [RULE_08]
        else $error("under level without pick-up");

    property p_prefault;
        @(posedge i_clk) disable iff (i_rst)
        $rose(r.out.start) |-> r.prefault == $past(avg);
    endproperty
    a_prefault: assert property (p_prefault) // see [RULE_02]
        else $error("pre-fault value not captured");

    c_trip: cover property (@(posedge i_clk) disable iff (i_rst) $rose(r.state == ST_TRIP));
    c_blocked: cover property (@(posedge i_clk) disable iff (i_rst)
        $rose(r.state == ST_BLOCKED));
    c_inhibit: cover property (@(posedge i_clk) disable iff (i_rst) $fell(r.inhibit));
    c_forced: cover property (@(posedge i_clk) disable iff (i_rst) $rose(r.force_act));
endmodule

`default_nettype wire

//--- hdl/uvp_pkg.sv
package uvp_pkg;
    // timing: one evaluation cycle, derived from the clock rate
    localparam int CLK_HZ           = 40_000_000;
    localparam int EVAL_MS          = 5;
    localparam int TICK_CYCLES_DFLT = CLK_HZ / 1000 * EVAL_MS;
    localparam int AVG_MS           = 20;
    localparam int AVG_TAPS         = AVG_MS / EVAL_MS;
    localparam int DT_DFLT_MS       = 40;

    // register word addresses
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_PICKUP = 4'h1;
    localparam logic [3:0] A_BLOCK  = 4'h2;
    localparam logic [3:0] A_DELAY  = 4'h3;
    localparam logic [3:0] A_SCALE  = 4'h4;
    localparam logic [3:0] A_STATUS = 4'h5;
    localparam logic [3:0] A_PRI_PU = 4'h6;
    localparam logic [3:0] A_PRI_BL = 4'h7;
    localparam logic [3:0] A_EXPECT = 4'h8;
    localparam logic [3:0] A_REMAIN = 4'h9;
    localparam logic [3:0] A_RATIO0 = 4'ha;
    localparam logic [3:0] A_RATIOM = 4'hd;
    localparam logic [3:0] A_PREF   = 4'he;

    // control word field positions
    localparam int CTRL_SEL   = 0;
    localparam int CTRL_ARR   = 2;
    localparam int CTRL_MODE  = 3;
    localparam int CTRL_FRC   = 6;
    localparam int CTRL_ALLOW = 8;
    localparam int CTRL_FEN   = 9;

    // reset values, levels in 0.01 % of nominal
    localparam logic [15:0] RST_PICKUP = 16'h1770;
    localparam logic [15:0] RST_BLOCK  = 16'h03e8;
    localparam logic [15:0] RST_DELAY  = 16'(DT_DFLT_MS / EVAL_MS);
    localparam logic [15:0] RST_SCALE  = 16'h03e8;

    // fixed ratios
    localparam logic [31:0] RESET_PCT   = 32'h0000_0067;
    localparam logic [31:0] HUNDRED     = 32'h0000_0064;
    localparam logic [31:0] PRIM_DIV    = 32'h0000_2710;

    // selection, mode and forcing codes
    localparam logic [1:0] SEL_PP  = 2'h0;
    localparam logic [1:0] SEL_PE  = 2'h1;
    localparam logic [1:0] SEL_CH3 = 2'h2;
    localparam logic [1:0] SEL_CH4 = 2'h3;
    localparam logic [2:0] MODE_ON   = 3'h1;
    localparam logic [2:0] MODE_BLK  = 3'h2;
    localparam logic [2:0] MODE_TEST = 3'h3;
    localparam logic [2:0] MODE_TBLK = 3'h4;
    localparam logic [2:0] MODE_OFF  = 3'h5;
    localparam logic [1:0] FRC_NORMAL = 2'h0;
    localparam logic [1:0] FRC_START  = 2'h1;
    localparam logic [1:0] FRC_TRIP   = 2'h2;
    localparam logic [1:0] FRC_BLOCK  = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_START   = 2'b01,
        ST_TRIP    = 2'b11,
        ST_BLOCKED = 2'b10
    } stage_e;

    // rms magnitudes, 0.01 % of nominal each
    typedef struct packed {
        logic [2:0][15:0] line;
        logic [2:0][15:0] phase;
        logic [15:0]      ch3;
        logic [15:0]      ch4;
    } meas_s;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } regbus_s;

    typedef struct packed {
        logic start;
        logic trip;
        logic blocked;
    } stage_out_s;
endpackage

//--- tb/meas_source.sv
`timescale 1ns/1ps
`default_nettype none

module meas_source (
    // clock
    input  wire logic           i_clk,
    // level control from the bench
    input  wire logic [15:0]    i_base,
    input  wire logic [15:0]    i_dip,
    input  wire logic [7:0]     i_mask,
    // rms magnitudes to the stage
    output uvp_pkg::meas_s      o_meas
);
    import uvp_pkg::*;

    // mask bits 0..2 line, 3..5 phase, 6 ch3, 7 ch4; a set bit sags that slot
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 3; k++) begin
            o_meas.line[k]  <= i_mask[k] ? i_dip : i_base;
            o_meas.phase[k] <= i_mask[k+3] ? i_dip : i_base;
        end
        o_meas.ch3 <= i_mask[6] ? i_dip : i_base;
        o_meas.ch4 <= i_mask[7] ? i_dip : i_base;
    end
endmodule

`default_nettype wire

//--- tb/undervoltage_pickup_block_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module undervoltage_pickup_block_tb_top;
    import uvp_pkg::*;
    localparam int P = 20;

    logic        i_clk;
    logic        i_rst;
    logic        i_ext_block;
    meas_s       i_meas;
    regbus_s     i_bus;
    logic [31:0] o_rdata;
    stage_out_s  o_stage;
    logic [15:0] base;
    logic [15:0] dip;
    logic [7:0]  mask;
    logic [31:0] d;
    int          err_count;
    int          total_checks;
    // addr and reset value pairs, unmapped address last
    logic [35:0] rst_tbl [9] = '{36'h000000008, 36'h100001770, 36'h2000003e8,
        36'h300000008, 36'h4000003e8, 36'h600000258, 36'h700000064,
        36'h800000008, 36'hf00000000};

    undervoltage_pickup_block #(.P_TICK_CYCLES(P)) undervoltage_pickup_block_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_meas(i_meas), .i_ext_block(i_ext_block),
        .i_bus(i_bus), .o_rdata(o_rdata), .o_stage(o_stage));

    meas_source meas_source_i (
        .i_clk(i_clk), .i_base(base), .i_dip(dip), .i_mask(mask), .o_meas(i_meas));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one gap cycle between strobes keeps each signal to one assignment a step
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_bus <= '{a, v, 1'b1, 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1 v = o_rdata;
    endtask

    task automatic setm(input logic [15:0] b, input logic [15:0] dv, input logic [7:0] m);
        @(posedge i_clk);
        base <= b;
        dip  <= dv;
        mask <= m;
    endtask

    task automatic ticks(input int n);
        repeat (n * P) @(posedge i_clk);
        #1;
    endtask

    // bounded wait for an output pattern, a timeout closes the run
    task automatic wait_st(input logic [2:0] e);
        int n;
        n = 0;
        while (o_stage !== e && n < 14 * P) begin
            @(posedge i_clk);
            #1 n++;
        end
        if (n == 14 * P) begin
            err_count++;
            end_sim();
        end else begin
            chk("stage", {29'h0, o_stage}, {29'h0, e});
        end
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] s, input logic [2:0] m,
                                        input logic [1:0] f, input logic [1:0] af);
        return {22'h0, af, f, m, 1'b0, s};
    endfunction

    initial begin
        i_rst = 1'b1;
        i_bus = '0;
        i_ext_block = 1'b0;
        base = 16'h2710;
        dip = 16'h0;
        mask = 8'h0;
        err_count = 0;
        total_checks = 0;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        // reset values, primary scaling and an unmapped read
        foreach (rst_tbl[i]) begin
            rd(rst_tbl[i][35:32], d);
            chk("reset", d, rst_tbl[i][31:0]);
        end
        wr(A_PRI_PU, 32'h1234);
        rd(A_PRI_PU, d);
        chk("ro", d, 32'h258);
        // one line sags to half the level: start, then trip after the delay
        ticks(5);
        setm(16'h2710, 16'h0bb8, 8'h02);
        wait_st(3'b100);
        rd(A_RATIO0 + 4'h1, d);
        chk("ratio", d, 32'h32);
        rd(A_RATIOM, d);
        chk("ratio_min", d, 32'h32);
        rd(A_PREF, d);
        chk("prefault", d, 32'h2710);
        ticks(5);
        chk("early", {29'h0, o_stage}, 32'h4);
        // five ticks counted of eight, three left
        rd(A_REMAIN, d);
        chk("remain", d, 32'h3);
        wait_st(3'b110);
        // 6150 is under 103 percent of 6000, 6200 is above
        setm(16'h2710, 16'h1806, 8'h02);
        ticks(3);
        chk("hyst", {29'h0, o_stage}, 32'h6);
        setm(16'h2710, 16'h1838, 8'h02);
        wait_st(3'b000);
        // external block present when pick-up occurs
        @(posedge i_clk);
        i_ext_block <= 1'b1;
        ticks(2);
        setm(16'h2710, 16'h0bb8, 8'h02);
        wait_st(3'b001);
        ticks(10);
        chk("blk_hold", {29'h0, o_stage}, 32'h1);
        @(posedge i_clk);
        i_ext_block <= 1'b0;
        setm(16'h2710, 16'h0, 8'h00);
        wait_st(3'b000);
        // dead network, then recovery only partway
        setm(16'h2710, 16'h01f4, 8'h07);
        ticks(12);
        chk("dead_trip", {31'h0, o_stage.trip}, 32'h0);
        setm(16'h2710, 16'h1388, 8'h07);
        ticks(12);
        rd(A_STATUS, d);
        chk("inhibit", {31'h0, d[4]}, 32'h1);
        chk("inh_start", {31'h0, o_stage.start}, 32'h0);
        setm(16'h2710, 16'h0, 8'h00);
        wait_st(3'b000);
        // zero block level turns the inhibit off
        wr(A_BLOCK, 32'h0);
        setm(16'h2710, 16'h01f4, 8'h07);
        wait_st(3'b100);
        setm(16'h2710, 16'h0, 8'h00);
        wr(A_BLOCK, 32'h3e8);
        wait_st(3'b000);
        // forced Start, Trip and Blocked states, then forcing disabled
        for (int f = 1; f < 4; f++) begin
            wr(A_CTRL, ctl(SEL_PP, MODE_ON, 2'(f), 2'h2));
            wait_st(f == 1 ? 3'b100 : f == 2 ? 3'b110 : 3'b001);
        end
        wr(A_CTRL, ctl(SEL_PP, MODE_ON, FRC_TRIP, 2'h0));
        wait_st(3'b000);
        // mode off only counts while individual mode is allowed
        wr(A_CTRL, ctl(SEL_PP, MODE_OFF, FRC_NORMAL, 2'h1));
        setm(16'h2710, 16'h0bb8, 8'h01);
        ticks(4);
        chk("off", {29'h0, o_stage}, 32'h0);
        rd(A_STATUS, d);
        chk("eff_mode", {29'h0, d[9:7]}, 32'h5);
        wr(A_CTRL, ctl(SEL_PP, MODE_OFF, FRC_NORMAL, 2'h0));
        wait_st(3'b100);
        setm(16'h2710, 16'h0, 8'h00);
        wait_st(3'b000);
        // fourth channel sags, only slot 0 is populated
        wr(A_CTRL, ctl(SEL_CH4, MODE_ON, FRC_NORMAL, 2'h0));
        setm(16'h2710, 16'h0bb8, 8'h80);
        wait_st(3'b100);
        rd(A_RATIO0, d);
        chk("ch4_ratio", d, 32'h32);
        setm(16'h2710, 16'h0, 8'h00);
        wait_st(3'b000);
        // phase-to-earth sag on the first slot
        wr(A_CTRL, ctl(SEL_PE, MODE_ON, FRC_NORMAL, 2'h0));
        setm(16'h2710, 16'h0bb8, 8'h08);
        wait_st(3'b100);
        // aux arrangement: third line slot and ch3 sag, neither is watched by P-P
        wr(A_CTRL, ctl(SEL_PP, MODE_ON, FRC_NORMAL, 2'h0) | 32'h4);
        setm(16'h2710, 16'h0bb8, 8'h44);
        ticks(4);
        chk("aux_pp", {29'h0, o_stage}, 32'h0);
        // third channel counts only with the aux arrangement
        wr(A_CTRL, ctl(SEL_CH3, MODE_ON, FRC_NORMAL, 2'h0) | 32'h4);
        wait_st(3'b100);
        wr(A_CTRL, ctl(SEL_CH3, MODE_ON, FRC_NORMAL, 2'h0));
        wait_st(3'b000);
        end_sim();
    end
endmodule

`default_nettype wire
